// ---- rtl/lpcs_pkg.sv ----
// Constants, enumerations and carriers for the link port configuration block
package lpcs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CYCLE  = 8'h04;
  localparam logic [7:0] REG_VENDOR = 8'h08;
  localparam logic [7:0] REG_DEVICE = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CSUM   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_VAL_LSB  = 4;
  localparam int CTRL_SWAP_LSB = 8;
  localparam int CTRL_MAP_LSB  = 16;
  localparam int QB_MISMATCH   = 0;
  localparam int QB_STORE      = 4;

  localparam logic [4:0]  MAP_LEN_RST = 5'h08;
  localparam logic [15:0] VENDOR_RST  = 16'h0000;
  localparam logic [23:0] DEVICE_RST  = 24'h000000;
  localparam logic [10:0] CYCLE_RST   = 11'h000;

  // ----------------------------------------------------------------
  // Cycle time in tenths of a millisecond; zero means automatic
  // ----------------------------------------------------------------
  localparam logic [10:0] CYC_AUTO     = 11'h000;
  localparam logic [10:0] CYC_FINE_LO  = 11'h004;
  localparam logic [10:0] CYC_FINE_HI  = 11'h03f;
  localparam logic [10:0] CYC_MID_LO   = 11'h040;
  localparam logic [10:0] CYC_MID_HI   = 11'h13c;
  localparam logic [10:0] CYC_COARSE_LO = 11'h140;
  localparam logic [10:0] CYC_COARSE_HI = 11'h530;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_AUTO    = 2'h0,
    MODE_MANUAL  = 2'h1,
    MODE_DIG_IN  = 2'h2,
    MODE_DIG_OUT = 2'h3
  } lpcs_mode_t;

  typedef enum logic [2:0] {
    VAL_NO_CHECK = 3'h0,
    VAL_V10      = 3'h1,
    VAL_V11      = 3'h2,
    VAL_V11_BR   = 3'h3,
    VAL_V11_R    = 3'h4
  } lpcs_val_t;

  typedef enum logic [1:0] {
    SWAP_DIRECT = 2'h0,
    SWAP_16     = 2'h1,
    SWAP_32     = 2'h2,
    SWAP_ALL    = 2'h3
  } lpcs_swap_t;

  typedef enum logic [1:0] {
    OP_NONE    = 2'h0,
    OP_CLEAR   = 2'h1,
    OP_BACKUP  = 2'h2,
    OP_RESTORE = 2'h3
  } lpcs_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_EVAL = 1'h1
  } lpcs_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    lpcs_swap_t mode;
    logic [4:0] map_len;
  } lpcs_swap_cfg_t;

  typedef struct packed {
    logic [15:0] vendor;
    logic [23:0] device;
    logic        rev11;
  } lpcs_ident_t;

endpackage : lpcs_pkg

// ---- rtl/lpcs_swap.sv ----
// Registered byte-order swap of one process data image
`timescale 1ns/10ps
`default_nettype none

module lpcs_swap #(
  parameter int NB = 16
) (
  input  wire logic                   clk_sys, // System clock
  input  wire logic                   sys_rst, // Async reset, high
  input  wire lpcs_pkg::lpcs_swap_cfg_t cfg,   // Swap mode and map size
  input  wire logic [4:0]             src_len, // Valid source bytes
  input  wire logic [8*NB-1:0]        din,     // Source image, byte 0 low
  output logic      [8*NB-1:0]        dout     // Swapped image
);

  logic [8*NB-1:0] img_d;
  logic [8*NB-1:0] dout_q;

  // ----------------------------------------------------------------
  // Byte selection
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0] i5;
    logic [4:0] j;
    i5    = 5'h00;
    j     = 5'h00;
    img_d = '0;
    for (int i = 0; i < NB; i++)
    begin
      i5 = 5'(i);
      case (cfg.mode)
        lpcs_pkg::SWAP_16:  j = i5 ^ 5'h01;
        lpcs_pkg::SWAP_32:  j = (cfg.map_len == 5'h02) ? i5 : (i5 ^ 5'h03);
        lpcs_pkg::SWAP_ALL: j = cfg.map_len - 5'h01 - i5;
        default:            j = i5;
      endcase
      // Pad bytes past the device data read as zero and still move
      if (i5 < cfg.map_len && j < cfg.map_len && j < src_len)
        img_d[8*i +: 8] = din[8*j +: 8];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      dout_q <= '0;
    else
      dout_q <= img_d;
  end

  assign dout = dout_q;

  chk_swap_all_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cfg.mode == lpcs_pkg::SWAP_ALL && cfg.map_len == 5'(NB) && src_len == 5'(NB))
      |=> dout[7:0] == $past(din[8*NB-1 -: 8]))
    else $error("Swap all did not move last byte to first");

endmodule : lpcs_swap

`default_nettype wire

// ---- rtl/lpcs_port.sv ----
// Link port configuration, identity check, swap and storage decision
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module lpcs_port #(
  parameter int NB = 16
) (
  input  wire logic                clk_sys,         // System clock
  input  wire logic                sys_rst,         // Async reset, high
  input  wire logic [7:0]          avs_address,     // Byte address
  input  wire logic                avs_read,        // Read request
  input  wire logic                avs_write,       // Write request
  input  wire logic [31:0]         avs_writedata,   // Write data
  output logic      [31:0]         avs_readdata,    // Read data
  output logic                     avs_waitrequest, // Stall
  input  wire logic                startup_req,     // Link start-up pulse
  input  wire lpcs_pkg::lpcs_ident_t dev_ident,     // Connected identity
  input  wire logic                dev_backup_req,  // Device wants backup
  input  wire logic [31:0]         dev_param_csum,  // Device checksum
  output logic                     link_start,      // Start link pulse
  output logic                     link_refused,    // Check failed pulse
  output lpcs_pkg::lpcs_op_t       store_op,        // Storage action
  output logic                     store_op_valid,  // Action pulse
  output logic      [10:0]         cycle_time,      // Tenths of ms, 0 auto
  output logic      [7:0]          port_qualifier_byte, // Port status
  input  wire logic [8*NB-1:0]     pd_in_dev,       // Device input image
  input  wire logic [4:0]          pd_in_dev_len,   // Device data bytes
  output logic      [8*NB-1:0]     pd_in_fb,        // To fieldbus
  input  wire logic [8*NB-1:0]     pd_out_fb,       // From fieldbus
  output logic      [8*NB-1:0]     pd_out_dev       // To device
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  lpcs_pkg::lpcs_mode_t  mode_q;
  lpcs_pkg::lpcs_val_t   val_q;
  lpcs_pkg::lpcs_swap_t  swap_q;
  lpcs_pkg::lpcs_state_t state_q;
  lpcs_pkg::lpcs_val_t   eff_val;
  lpcs_pkg::lpcs_op_t    op_d;
  lpcs_pkg::lpcs_op_t    op_q;
  lpcs_pkg::lpcs_ident_t id_q;
  lpcs_pkg::lpcs_swap_cfg_t swap_cfg;
  logic [4:0]  map_len_q;
  logic [10:0] cycle_q;
  logic [15:0] vendor_q;
  logic [23:0] device_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        wr_fire;
  logic        bkreq_q;
  logic [31:0] csum_q;
  logic        stored_valid_q;
  logic [31:0] stored_csum_q;
  logic        mismatch_q;
  logic        start_q;
  logic        refused_q;
  logic        op_valid_q;
  logic        cmp_en;
  logic        store_active;
  logic        id_differs;
  logic        bus_clear;
  logic        eval_set;
  logic        eval_clear;
  logic [7:0]  qual_byte;

  // ----------------------------------------------------------------
  // Bus slave: one wait state, write takes effect on the release edge
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_fire         = avs_write & ack_q;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      case (avs_address)
        lpcs_pkg::REG_CTRL:   rdata_q <= {11'h000, map_len_q, 6'h00, swap_q,
                                          1'b0, val_q, 2'h0, mode_q};
        lpcs_pkg::REG_CYCLE:  rdata_q <= {21'h000000, cycle_q};
        lpcs_pkg::REG_VENDOR: rdata_q <= {16'h0000, vendor_q};
        lpcs_pkg::REG_DEVICE: rdata_q <= {8'h00, device_q};
        lpcs_pkg::REG_STATUS: rdata_q <= {24'h000000, qual_byte};
        lpcs_pkg::REG_CSUM:   rdata_q <= stored_csum_q;
        default:              rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  function automatic logic cyc_ok(input logic [10:0] v);
    cyc_ok = (v == lpcs_pkg::CYC_AUTO)
          || (v >= lpcs_pkg::CYC_FINE_LO && v <= lpcs_pkg::CYC_FINE_HI)
          || (v >= lpcs_pkg::CYC_MID_LO && v <= lpcs_pkg::CYC_MID_HI
              && v[1:0] == 2'h0)
          || (v >= lpcs_pkg::CYC_COARSE_LO && v <= lpcs_pkg::CYC_COARSE_HI
              && v[3:0] == 4'h0);
  endfunction : cyc_ok

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q    <= lpcs_pkg::MODE_AUTO;
      val_q     <= lpcs_pkg::VAL_NO_CHECK;
      swap_q    <= lpcs_pkg::SWAP_DIRECT;
      map_len_q <= lpcs_pkg::MAP_LEN_RST;
    end
    else if (wr_fire && avs_address == lpcs_pkg::REG_CTRL)
    begin
      mode_q <= lpcs_pkg::lpcs_mode_t'(avs_writedata[lpcs_pkg::CTRL_MODE_LSB +: 2]);
      // Unknown validation codes fall back to no check
      if (avs_writedata[lpcs_pkg::CTRL_VAL_LSB +: 3] <= 3'h4)
        val_q <= lpcs_pkg::lpcs_val_t'(avs_writedata[lpcs_pkg::CTRL_VAL_LSB +: 3]);
      else
        val_q <= lpcs_pkg::VAL_NO_CHECK;
      swap_q <= lpcs_pkg::lpcs_swap_t'(avs_writedata[lpcs_pkg::CTRL_SWAP_LSB +: 2]);
      // Map size beyond the image width would index past the buffer
      if (avs_writedata[lpcs_pkg::CTRL_MAP_LSB +: 5] <= 5'(NB))
        map_len_q <= avs_writedata[lpcs_pkg::CTRL_MAP_LSB +: 5];
    end
  end

  // Illegal step values are dropped, previous value kept
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cycle_q <= lpcs_pkg::CYCLE_RST;
    else if (wr_fire && avs_address == lpcs_pkg::REG_CYCLE
             && avs_writedata[31:11] == 21'h000000
             && cyc_ok(avs_writedata[10:0]))
      cycle_q <= avs_writedata[10:0];
  end

  assign cycle_time = cycle_q;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vendor_q <= lpcs_pkg::VENDOR_RST;
      device_q <= lpcs_pkg::DEVICE_RST;
    end
    else if (wr_fire && avs_address == lpcs_pkg::REG_VENDOR)
      vendor_q <= avs_writedata[15:0];
    else if (wr_fire && avs_address == lpcs_pkg::REG_DEVICE)
      device_q <= avs_writedata[23:0];
  end

  // ----------------------------------------------------------------
  // Effective validation and identity comparison
  // ----------------------------------------------------------------
  always_comb
  begin
    eff_val = (mode_q == lpcs_pkg::MODE_MANUAL) ? val_q
                                                : lpcs_pkg::VAL_NO_CHECK;
    cmp_en  = (eff_val != lpcs_pkg::VAL_NO_CHECK);
    store_active = (eff_val == lpcs_pkg::VAL_V11_BR)
                || (eff_val == lpcs_pkg::VAL_V11_R);
    id_differs = (id_q.vendor != vendor_q) || (id_q.device != device_q)
              || (id_q.rev11 != (eff_val != lpcs_pkg::VAL_V10));
  end

  // Storage decision taken once per start-up
  always_comb
  begin
    case (eff_val)
      lpcs_pkg::VAL_V11_BR:
        if (!stored_valid_q || bkreq_q)
          op_d = lpcs_pkg::OP_BACKUP;
        else if (stored_csum_q != csum_q)
          op_d = lpcs_pkg::OP_RESTORE;
        else
          op_d = lpcs_pkg::OP_NONE;
      lpcs_pkg::VAL_V11_R:
        if (stored_valid_q && stored_csum_q != csum_q)
          op_d = lpcs_pkg::OP_RESTORE;
        else
          op_d = lpcs_pkg::OP_NONE;
      default:
        op_d = lpcs_pkg::OP_CLEAR;
    endcase
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= lpcs_pkg::ST_IDLE;
      id_q    <= '0;
      bkreq_q <= 1'b0;
      csum_q  <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        lpcs_pkg::ST_IDLE:
          // Digital sub-module modes never bring the link up
          if (startup_req && (mode_q == lpcs_pkg::MODE_AUTO
                              || mode_q == lpcs_pkg::MODE_MANUAL))
          begin
            state_q <= lpcs_pkg::ST_EVAL;
            id_q    <= dev_ident;
            bkreq_q <= dev_backup_req;
            csum_q  <= dev_param_csum;
          end
        lpcs_pkg::ST_EVAL:
          state_q <= lpcs_pkg::ST_IDLE;
        default:
          state_q <= lpcs_pkg::ST_IDLE;
      endcase
    end
  end

  // Mismatched device holds the link down and an action of none
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_q    <= 1'b0;
      refused_q  <= 1'b0;
      mismatch_q <= 1'b0;
      op_q       <= lpcs_pkg::OP_NONE;
      op_valid_q <= 1'b0;
    end
    else if (state_q == lpcs_pkg::ST_EVAL)
    begin
      mismatch_q <= cmp_en && id_differs;
      start_q    <= !(cmp_en && id_differs);
      refused_q  <= cmp_en && id_differs;
      op_q       <= (cmp_en && id_differs) ? lpcs_pkg::OP_NONE : op_d;
      op_valid_q <= 1'b1;
    end
    else
    begin
      start_q    <= 1'b0;
      refused_q  <= 1'b0;
      op_valid_q <= 1'b0;
    end
  end

  assign link_start     = start_q;
  assign link_refused   = refused_q;
  assign store_op       = op_q;
  assign store_op_valid = op_valid_q;

  // ----------------------------------------------------------------
  // Parameter storage bookkeeping; a backup wins over a bus clear
  // ----------------------------------------------------------------
  assign eval_set   = (state_q == lpcs_pkg::ST_EVAL) && !(cmp_en && id_differs)
                   && (op_d == lpcs_pkg::OP_BACKUP);
  assign eval_clear = (state_q == lpcs_pkg::ST_EVAL) && !(cmp_en && id_differs)
                   && (op_d == lpcs_pkg::OP_CLEAR);
  assign bus_clear  = wr_fire && (
      (avs_address == lpcs_pkg::REG_VENDOR
       && avs_writedata[15:0] != vendor_q)
   || (avs_address == lpcs_pkg::REG_DEVICE
       && avs_writedata[23:0] != device_q)
   || (avs_address == lpcs_pkg::REG_CTRL && mode_q == lpcs_pkg::MODE_MANUAL
       && avs_writedata[lpcs_pkg::CTRL_MODE_LSB +: 2] != 2'(lpcs_pkg::MODE_MANUAL)));

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stored_valid_q <= 1'b0;
      stored_csum_q  <= 32'h0000_0000;
    end
    else if (eval_set)
    begin
      stored_valid_q <= 1'b1;
      stored_csum_q  <= csum_q;
    end
    else if (eval_clear || bus_clear)
    begin
      stored_valid_q <= 1'b0;
      stored_csum_q  <= 32'h0000_0000;
    end
  end

  always_comb
  begin
    qual_byte = 8'h00;
    qual_byte[lpcs_pkg::QB_MISMATCH] = mismatch_q;
    qual_byte[lpcs_pkg::QB_STORE]    = store_active && stored_valid_q;
  end

  assign port_qualifier_byte = qual_byte;

  // ----------------------------------------------------------------
  // Process data swap, both directions share one setting
  // ----------------------------------------------------------------
  assign swap_cfg = '{mode: swap_q, map_len: map_len_q};

  lpcs_swap #(.NB(NB)) u_swap_in (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cfg     (swap_cfg),
    .src_len (pd_in_dev_len),
    .din     (pd_in_dev),
    .dout    (pd_in_fb)
  );

  lpcs_swap #(.NB(NB)) u_swap_out (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cfg     (swap_cfg),
    .src_len (map_len_q),
    .din     (pd_out_fb),
    .dout    (pd_out_dev)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_auto_start: assert property (
    (state_q == lpcs_pkg::ST_IDLE && startup_req
     && mode_q == lpcs_pkg::MODE_AUTO) |=> ##1 link_start)
    else $error("Autostart did not start link two cycles later");

  chk_manual_gate: assert property (
    link_start |-> !mismatch_q && !link_refused)
    else $error("Link started despite identity mismatch");

  chk_mismatch_flag: assert property (
    (state_q == lpcs_pkg::ST_EVAL && cmp_en && id_differs)
      |=> port_qualifier_byte[0] && link_refused && !link_start)
    else $error("Identity mismatch not flagged");

  chk_clear_nostore: assert property (
    (state_q == lpcs_pkg::ST_EVAL && !store_active && !(cmp_en && id_differs))
      |=> store_op_valid && store_op == lpcs_pkg::OP_CLEAR && !stored_valid_q)
    else $error("Non-storage setting did not clear storage");

  chk_backup_empty: assert property (
    (state_q == lpcs_pkg::ST_EVAL && eff_val == lpcs_pkg::VAL_V11_BR
     && !id_differs && (!stored_valid_q || bkreq_q))
      |=> store_op == lpcs_pkg::OP_BACKUP && stored_valid_q
          && stored_csum_q == $past(csum_q))
    else $error("Backup not taken");

  chk_restore_only: assert property (
    (state_q == lpcs_pkg::ST_EVAL && eff_val == lpcs_pkg::VAL_V11_R
     && !id_differs)
      |=> store_op == (($past(stored_valid_q)
                        && $past(stored_csum_q) != $past(csum_q))
                       ? lpcs_pkg::OP_RESTORE : lpcs_pkg::OP_NONE))
    else $error("Restore-only decision wrong");

  chk_id_clear: assert property (
    (bus_clear && state_q == lpcs_pkg::ST_IDLE) |=> !stored_valid_q)
    else $error("Changed identifier did not clear storage");

  chk_mode_clear: assert property (
    (wr_fire && avs_address == lpcs_pkg::REG_CTRL
     && mode_q == lpcs_pkg::MODE_MANUAL && state_q == lpcs_pkg::ST_IDLE
     && avs_writedata[1:0] != 2'h1) |=> !stored_valid_q ##0 !port_qualifier_byte[4])
    else $error("Leaving manual did not clear storage");

  chk_status_bit: assert property (
    port_qualifier_byte[4] |-> mode_q == lpcs_pkg::MODE_MANUAL && stored_valid_q)
    else $error("Storage bit set outside manual storage use");

  chk_bus_wait: assert property (
    (avs_read && !ack_q) |=> !avs_waitrequest [*1] ##1 !ack_q)
    else $error("Bus answer not after one wait state");

endmodule : lpcs_port

`default_nettype wire

// ---- dv/lpcs_dev_model.sv ----
// Connected link device model: identity, checksum, input image
`timescale 1ns/10ps
`default_nettype none

module lpcs_dev_model #(
  parameter logic [15:0] VID = 16'h5a5a,  // Arbitrary vendor code
  parameter logic [23:0] DID = 24'h00c3c3 // Arbitrary device code
) (
  input  wire logic             rev11,  // Device speaks V1.1
  input  wire logic             bk_req, // Device asks for backup
  input  wire logic [31:0]      csum,   // Parameter checksum
  input  wire logic [4:0]       len,    // Input data bytes
  output lpcs_pkg::lpcs_ident_t ident,  // Reported identity
  output logic                  backup, // Backup request line
  output logic      [31:0]      csum_o, // Checksum line
  output logic      [127:0]     img     // Input image
);
  // Bytes past the device length are junk, so padding must zero them
  always_comb
  begin
    ident = '{vendor: VID, device: DID, rev11: rev11};
    backup = bk_req;
    csum_o = csum;
    for (int i = 0; i < 16; i++)
      img[8*i+:8] = (i < len) ? 8'(8'h10 + i) : 8'hee;
  end
endmodule : lpcs_dev_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the link port configuration block
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, a) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      n_fail++; \
      $display("mismatch %s exp %h got %h", n, e, a); \
    end \
  end

module tb;
  localparam logic [15:0] VID = 16'h5a5a;   // Arbitrary value
  localparam logic [23:0] DID = 24'h00c3c3; // Arbitrary value
  logic clk_sys = 0, sys_rst = 1, rd = 0, wr = 0, su = 0, wt;
  logic rev11 = 1, bk = 0, ls, lr, ov, bkl;
  logic [7:0] adr = 0, qb;
  logic [31:0] wd = 0, rdat, q, cs = 32'h1111, cso;
  logic [4:0] len = 5'h0a;
  logic [10:0] cyc;
  logic [127:0] img, fb = 128'h3f3e3d3c3b3a39383736353433323130;
  logic [127:0] in_fb, out_dev;
  lpcs_pkg::lpcs_ident_t idt;
  lpcs_pkg::lpcs_op_t op;
  int n_fail = 0, total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  lpcs_dev_model #(.VID(VID), .DID(DID)) peer (.rev11(rev11), .bk_req(bk),
    .csum(cs), .len(len), .ident(idt), .backup(bkl), .csum_o(cso),
    .img(img));

  lpcs_port #(.NB(16)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .startup_req(su),
    .dev_ident(idt), .dev_backup_req(bkl), .dev_param_csum(cso),
    .link_start(ls), .link_refused(lr), .store_op(op),
    .store_op_valid(ov), .cycle_time(cyc), .port_qualifier_byte(qb),
    .pd_in_dev(img), .pd_in_dev_len(len), .pd_in_fb(in_fb),
    .pd_out_fb(fb), .pd_out_dev(out_dev));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk_sys); while (wt !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge clk_sys);
  endtask : bus

  task automatic st(input logic es, input lpcs_pkg::lpcs_op_t eo);
    int n;
    n = 0;
    su <= 1;
    @(posedge clk_sys);
    su <= 0;
    while (ov !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("start", es, ls)
    `CHK("refused", !es, lr)
    `CHK("op", eo, op)
    `CHK("valid", 1'b1, ov)
    @(posedge clk_sys);
  endtask : st

  function automatic logic [31:0] ctl(input int m, v, s, l);
    ctl = 32'(m) | 32'(v) << 4 | 32'(s) << 8 | 32'(l) << 16;
  endfunction : ctl

  // Expected image: zero pad past device length, swap over the map
  function automatic logic [127:0] xs(input int m, ml, sl,
                                      input logic [127:0] s);
    int j;
    xs = '0;
    for (int i = 0; i < ml; i++)
    begin
      j = m == 1 ? i ^ 1 : (m == 2 && ml != 2) ? i ^ 3 : m == 3 ? ml-1-i : i;
      if (j < ml && j < sl)
        xs[8*i+:8] = s[8*j+:8];
    end
  endfunction : xs

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    bus(8'h00, 0, 0);
    `CHK("ctrl", 32'h00080000, q)
    bus(8'h08, 0, 0);
    `CHK("vendor", 32'h0, q)
    bus(8'h20, 0, 0);
    `CHK("unmapped", 32'h0, q)
    `CHK("cycle", 11'h000, cyc)
    bus(8'h04, 1, 32'h4);
    bus(8'h04, 1, 32'h41);
    `CHK("cycle", 11'h004, cyc)
    bus(8'h04, 1, 32'h530);
    `CHK("cycle", 11'h530, cyc)
    for (int m = 0; m < 5; m++)
    begin
      int sw;
      int ml;
      // Last pass: 32-bit swap on a two-byte map must leave order alone
      sw = m < 4 ? m : 2;
      ml = m < 4 ? 16 : 2;
      bus(8'h00, 1, ctl(0, 0, sw, ml));
      repeat (3) @(posedge clk_sys);
      `CHK("in", xs(sw, ml, 10, img), in_fb)
      `CHK("out", xs(sw, ml, 16, fb), out_dev)
    end
    bus(8'h00, 1, ctl(0, 3, 0, 8));
    st(1, lpcs_pkg::OP_CLEAR);
    bus(8'h08, 1, 32'(VID));
    bus(8'h0c, 1, 32'(DID));
    bus(8'h00, 1, ctl(1, 3, 0, 8));
    st(1, lpcs_pkg::OP_BACKUP);
    bus(8'h10, 0, 0);
    `CHK("status", 32'h10, q)
    `CHK("qual", 8'h10, qb)
    bus(8'h14, 0, 0);
    `CHK("csum", 32'h1111, q)
    st(1, lpcs_pkg::OP_NONE);
    cs <= 32'h2222;
    st(1, lpcs_pkg::OP_RESTORE);
    bk <= 1;
    st(1, lpcs_pkg::OP_BACKUP);
    bk <= 0;
    bus(8'h00, 1, ctl(1, 4, 0, 8));
    cs <= 32'h3333;
    st(1, lpcs_pkg::OP_RESTORE);
    cs <= 32'h2222;
    st(1, lpcs_pkg::OP_NONE);
    bus(8'h08, 1, 32'h1);
    st(0, lpcs_pkg::OP_NONE);
    bus(8'h10, 0, 0);
    `CHK("status", 32'h01, q)
    `CHK("qual", 8'h01, qb)
    bus(8'h08, 1, 32'(VID));
    st(1, lpcs_pkg::OP_NONE);
    bus(8'h00, 1, ctl(1, 3, 0, 8));
    st(1, lpcs_pkg::OP_BACKUP);
    bus(8'h00, 1, ctl(0, 3, 0, 8));
    bus(8'h00, 1, ctl(1, 3, 0, 8));
    bus(8'h10, 0, 0);
    `CHK("status", 32'h00, q)
    bus(8'h0c, 1, 32'h1);
    st(0, lpcs_pkg::OP_NONE);
    bus(8'h0c, 1, 32'(DID));
    bus(8'h00, 1, ctl(1, 1, 0, 8));
    st(0, lpcs_pkg::OP_NONE);
    rev11 <= 0;
    st(1, lpcs_pkg::OP_CLEAR);
    rev11 <= 1;
    bus(8'h08, 1, 32'h7);
    bus(8'h00, 1, ctl(1, 0, 0, 8));
    st(1, lpcs_pkg::OP_CLEAR);
    bus(8'h08, 1, 32'(VID));
    bus(8'h00, 1, ctl(1, 2, 0, 8));
    st(1, lpcs_pkg::OP_CLEAR);
    rev11 <= 0;
    st(0, lpcs_pkg::OP_NONE);
    rev11 <= 1;
    // Unknown validation code reads back as no check, oversize map dropped and previous size kept
    bus(8'h00, 1, ctl(1, 7, 0, 17));
    bus(8'h00, 0, 0);
    `CHK("ctrl", 32'h00080001, q)
    // Digital sub-module mode: start-up request must stay unanswered
    bus(8'h00, 1, ctl(2, 3, 0, 8));
    su <= 1;
    @(posedge clk_sys);
    su <= 0;
    repeat (2) @(posedge clk_sys);
    `CHK("dig", 2'h0, {ls, ov})
    finish_test();
  end
endmodule : tb

`default_nettype wire
